// ===== hw/irq_err_defs.vh
// Purpose: Constants for the interrupt and command error flag registers
// Assumes: 8-bit register data, 6-bit register address
// Notes: Included by the two register design files of this block, not by the synchroniser
`ifndef IRQ_ERR_DEFS_VH
`define IRQ_ERR_DEFS_VH

// -----------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------
`define ADDR_MISC_IRQ_FLAGS 6'h05
`define ADDR_CMD_ERROR_FLAGS 6'h06

// -----------------------------------------------------------------
// Miscellaneous interrupt register fields
// -----------------------------------------------------------------
`define MISC_SET_CLEAR_BIT 7
`define MISC_EXT_EDGE_BIT 4
`define MISC_CHECKSUM_BIT 2
`define MISC_LOW_MASK 8'h0f
`define MISC_IRQ_MASK 8'h14

// -----------------------------------------------------------------
// Command error register fields
// -----------------------------------------------------------------
`define ERR_WRITE_MISUSE_BIT 7
`define ERR_OVERTEMP_BIT 6
`define ERR_RESERVED_BIT 5
`define ERR_OVERFLOW_BIT 4
`define ERR_COLLISION_BIT 3
`define ERR_CHECKSUM_BIT 2
`define ERR_PARITY_BIT 1
`define ERR_FRAME_START_BIT 0
`define ERR_RESET_VALUE 8'h00
`define ERR_KEEP_ON_CMD 8'h40
`define ERR_RX_STARTUP_CLEAR 8'h0f

`endif

// ===== hw/edge_sync.v
// Purpose: Three-stage synchroniser with agreed-level edge detection
// Assumes: Input is asynchronous to clk
// Notes: A change counts once stages two and three agree on it

`timescale 1ns/1ps

module edge_sync (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Raw pin and detected edge
	input wire pinIn,
	output reg edgeSeen
);

	reg stage1;
	reg stage2;
	reg stage3;
	reg level;

	// -----------------------------------------------------------------
	// Synchroniser chain; stage1 feeds only stage2 to limit metastability
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level <= 1'b0;
			edgeSeen <= 1'b0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			edgeSeen <= 1'b0;
			// Either direction counts once the two late stages agree
			if ((stage2 == stage3) && (stage3 != level)) begin
				level <= stage3;
				edgeSeen <= 1'b1;
			end
		end
	end

endmodule

// ===== hw/misc_irq_reg.v
// Purpose: Miscellaneous interrupt flag register with set/clear select
// Assumes: Events are one-cycle pulses on clk
// Notes: Only bits 4 and 2 are stored; others read zero

`include "irq_err_defs.vh"
`timescale 1ns/1ps

module misc_irq_reg (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Host write
	input wire wrEn,
	input wire [7:0] wrData,
	// Events
	input wire extEdge,
	input wire checksumDone,
	// Register value
	output reg [7:0] flags
);

	reg [7:0] next_flags;
	reg [7:0] written;

	// Host write first, hardware sets last so a set wins over a clear
	always @* begin
		next_flags = flags;
		written = wrData & `MISC_IRQ_MASK;
		if (wrEn) begin
			if (wrData[`MISC_SET_CLEAR_BIT])
				next_flags = flags | written;
			else
				next_flags = flags & ~written;
		end
		if (extEdge)
			next_flags[`MISC_EXT_EDGE_BIT] = 1'b1;
		if (checksumDone)
			next_flags[`MISC_CHECKSUM_BIT] = 1'b1;
		next_flags = next_flags & `MISC_IRQ_MASK;
	end

	// -----------------------------------------------------------------
	// Flag storage; no hardware clear path exists
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			flags <= 8'h00;
		end else begin
			flags <= next_flags;
		end
	end

endmodule

// ===== hw/irq_and_error_status_regs.v
// Purpose: Interrupt and command error status registers of a reader front end
// Assumes: Host register port is a simple strobe interface on clk
// Notes: Event inputs from same-clock engines are single-cycle pulses

`include "irq_err_defs.vh"
`timescale 1ns/1ps

module irq_and_error_status_regs (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Host register port
	input wire regWrite,
	input wire regRead,
	input wire [5:0] regAddr,
	input wire [7:0] regWrData,
	output reg [7:0] regRdData,
	// Card-side pin
	input wire card_side_serial_input,
	// Command state
	input wire cmdStart,
	input wire standalone_checksum_cmd,
	input wire card_authenticate_cmd,
	input wire checksumAllProcessed,
	// FIFO and RF events
	input wire hostFifoWrite,
	input wire engineFifoWrite,
	input wire fifoFull,
	input wire rfLastTxSent,
	input wire rfLastRxDone,
	// Receiver events
	input wire rxStartup,
	input wire rate106k,
	input wire typeA,
	input wire rx_checksum_check_enable,
	input wire collisionSeen,
	input wire checksumFail,
	input wire parityFail,
	input wire badStartOfFrame,
	input wire authByteCountBad,
	// Temperature sensor
	input wire overheat,
	// Status outputs
	output reg any_error_irq,
	output reg antennaOff,
	output reg [7:0] misc_irq_flags,
	output reg [7:0] command_error_flags
);

	// -----------------------------------------------------------------
	// Internal signals
	// -----------------------------------------------------------------
	wire extEdge;
	wire [7:0] miscValue;
	reg rfWindow;
	reg [7:0] errFlags;
	reg [7:0] next_errFlags;
	reg [7:0] next_rdData;
	reg overheatSync1;
	reg overheatSync2;
	reg overheatSync3;
	reg overheatLevel;

	// Address match helper shared by read and write decode
	function addrHit;
		input [5:0] addr;
		input [5:0] target;
		begin
			addrHit = (addr == target);
		end
	endfunction

	// -----------------------------------------------------------------
	// Card-side pin edge detection
	// -----------------------------------------------------------------
	edge_sync u_edge_sync (
		.clk(clk),
		.nrst(nrst),
		.pinIn(card_side_serial_input),
		.edgeSeen(extEdge)
	);

	// -----------------------------------------------------------------
	// Miscellaneous interrupt register
	// -----------------------------------------------------------------
	// only host writes clear flags
	misc_irq_reg u_misc_irq_reg (
		.clk(clk),
		.nrst(nrst),
		.wrEn(regWrite && addrHit(regAddr, `ADDR_MISC_IRQ_FLAGS)),
		.wrData(regWrData),
		.extEdge(extEdge),
		.checksumDone(standalone_checksum_cmd && checksumAllProcessed),
		.flags(miscValue)
	);

	// -----------------------------------------------------------------
	// Overheat input; sensor may be asynchronous, so three stages
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			overheatSync1 <= 1'b0;
			overheatSync2 <= 1'b0;
			overheatSync3 <= 1'b0;
			overheatLevel <= 1'b0;
		end else begin
			overheatSync1 <= overheat;
			overheatSync2 <= overheatSync1;
			overheatSync3 <= overheatSync2;
			if (overheatSync2 == overheatSync3)
				overheatLevel <= overheatSync3;
		end
	end

	// -----------------------------------------------------------------
	// RF window between last sent bit and last received bit
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			rfWindow <= 1'b0;
		end else if (rfLastRxDone) begin
			rfWindow <= 1'b0;
		end else if (rfLastTxSent) begin
			rfWindow <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Error flag next state
	// -----------------------------------------------------------------
	// Clears come first and sets last, so an event in a clearing cycle
	// is kept. Host register writes never reach this logic.
	always @* begin
		next_errFlags = errFlags;
		if (cmdStart)
			next_errFlags = errFlags & `ERR_KEEP_ON_CMD;
		if (rxStartup)
			next_errFlags = next_errFlags & ~`ERR_RX_STARTUP_CLEAR;
		if (hostFifoWrite && (card_authenticate_cmd || rfWindow))
			next_errFlags[`ERR_WRITE_MISUSE_BIT] = 1'b1;
		if (overheatLevel)
			next_errFlags[`ERR_OVERTEMP_BIT] = 1'b1;
		if ((hostFifoWrite || engineFifoWrite) && fifoFull)
			next_errFlags[`ERR_OVERFLOW_BIT] = 1'b1;
		if (collisionSeen && rate106k)
			next_errFlags[`ERR_COLLISION_BIT] = 1'b1;
		if (checksumFail && rx_checksum_check_enable)
			next_errFlags[`ERR_CHECKSUM_BIT] = 1'b1;
		// parity at 106 kBd type A
		if (parityFail && rate106k && typeA)
			next_errFlags[`ERR_PARITY_BIT] = 1'b1;
		if ((badStartOfFrame && rate106k) || (authByteCountBad && card_authenticate_cmd))
			next_errFlags[`ERR_FRAME_START_BIT] = 1'b1;
		next_errFlags[`ERR_RESERVED_BIT] = 1'b0;
	end

	// -----------------------------------------------------------------
	// Error register; holds since no write path exists
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			errFlags <= `ERR_RESET_VALUE;
		end else begin
			errFlags <= next_errFlags;
		end
	end

	// -----------------------------------------------------------------
	// Read data mux; unmapped addresses read zero
	// -----------------------------------------------------------------
	always @* begin
		next_rdData = regRdData;
		if (regRead) begin
			if (addrHit(regAddr, `ADDR_MISC_IRQ_FLAGS))
				next_rdData = miscValue;
			else if (addrHit(regAddr, `ADDR_CMD_ERROR_FLAGS))
				next_rdData = errFlags;
			else
				next_rdData = 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// Registered outputs
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			regRdData <= 8'h00;
			any_error_irq <= 1'b0;
			antennaOff <= 1'b0;
			misc_irq_flags <= 8'h00;
			command_error_flags <= `ERR_RESET_VALUE;
		end else begin
			regRdData <= next_rdData;
			any_error_irq <= (next_errFlags != 8'h00);
			antennaOff <= next_errFlags[`ERR_OVERTEMP_BIT];
			misc_irq_flags <= miscValue;
			command_error_flags <= next_errFlags;
		end
	end

endmodule

// ===== dv/irq_err_monitor.sv
// Purpose: Port checker for the status flag registers
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound onto the top module by name
`timescale 1ns/1ps
module irq_err_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Host write port
	input wire logic regWrite,
	input wire logic [5:0] regAddr,
	input wire logic [7:0] regWrData,
	// Command and event inputs
	input wire logic standalone_checksum_cmd,
	input wire logic card_authenticate_cmd,
	input wire logic checksumAllProcessed,
	input wire logic cmdStart,
	input wire logic hostFifoWrite,
	input wire logic fifoFull,
	input wire logic collisionSeen,
	input wire logic rate106k,
	// Status outputs
	input wire logic any_error_irq,
	input wire logic antennaOff,
	input wire logic [7:0] misc_irq_flags,
	input wire logic [7:0] command_error_flags
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----
	// Misc flags lag their cause by two edges
	// ----
	sequence set_write;
		regWrite && regAddr == 6'h05 && regWrData[7] && regWrData[4];
	endsequence
	sequence checksum_finish;
		standalone_checksum_cmd && checksumAllProcessed;
	endsequence
	chk_misc_set_write: assert property (set_write |-> ##2 misc_irq_flags[4])
		else $error("misc set write lost");
	chk_checksum_done: assert property (checksum_finish |-> ##2 misc_irq_flags[2])
		else $error("checksum done flag missing");
	chk_misc_reserved: assert property ((misc_irq_flags & 8'heb) == 8'h00)
		else $error("misc reserved bit set");
	chk_reset_zero: assert property ($rose(nrst) |->
		command_error_flags == 8'h00 && misc_irq_flags[3:0] == 4'h0)
		else $error("flags not zero after reset");
	// ----
	// Error flags, one edge after the event
	// ----
	chk_auth_misuse: assert property (card_authenticate_cmd && hostFifoWrite |=> command_error_flags[7])
		else $error("write misuse not flagged");
	chk_overflow_set: assert property (fifoFull && hostFifoWrite |=> command_error_flags[4])
		else $error("overflow not flagged");
	chk_no_fast_coll: assert property (collisionSeen && !rate106k && !command_error_flags[3]
		|=> !command_error_flags[3])
		else $error("collision flagged off rate");
	chk_temp_kept: assert property (cmdStart && command_error_flags[6] |=> command_error_flags[6])
		else $error("overtemperature lost on command");
	chk_err_reserved: assert property (!command_error_flags[5])
		else $error("error reserved bit set");
	chk_antenna_tie: assert property (antennaOff == command_error_flags[6])
		else $error("antenna off mismatch");
	chk_irq_tracks_err: assert property (any_error_irq == (command_error_flags != 8'h00))
		else $error("error irq mismatch");
endmodule
bind irq_and_error_status_regs irq_err_monitor u_monitor (.*);

// ===== dv/host_model.sv
// Purpose: Host side register access model
// Assumes: One-cycle strobes launched after a rising edge
// Notes: Idle bus points at an unmapped address
`timescale 1ns/1ps
module host_model (
	// Clock and read data
	input wire logic clk,
	input wire logic [7:0] regRdData,
	// Strobes, address, write data
	output logic regWrite,
	output logic regRead,
	output logic [5:0] regAddr,
	output logic [7:0] regWrData
);
	// Idle values so a stray strobe hits nothing
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 6'h3f;
		regWrData = 8'h00;
	end
	// bit 7 picks set or clear
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge clk) {regWrite, regAddr, regWrData} <= {1'b0, 6'h3f, ~d};
	endtask
	// Read data is registered, taken after the strobe edge
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk) {regRead, regAddr} <= {1'b1, a};
		@(posedge clk) {regRead, regAddr} <= {1'b0, 6'h3f};
		@(posedge clk) #1 d = regRdData;
	endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the status flag registers
// Assumes: Host model drives the register strobes
// Notes: Event pulses and levels go through two vectors
`timescale 1ns/1ps
module tb_top;
	logic clk, nrst, card_side_serial_input, regWrite, regRead, any_error_irq, antennaOff;
	logic [11:0] ev;
	logic [6:0] lv;
	logic [5:0] regAddr;
	logic [7:0] regWrData, regRdData, misc_irq_flags, command_error_flags, rd;
	logic cmdStart, checksumAllProcessed, hostFifoWrite, engineFifoWrite, rfLastTxSent;
	logic rfLastRxDone, rxStartup, collisionSeen, checksumFail, parityFail, badStartOfFrame;
	logic authByteCountBad, standalone_checksum_cmd, card_authenticate_cmd, fifoFull;
	logic rate106k, typeA, rx_checksum_check_enable, overheat;
	int failures = 0, nTests = 0, cyc = 0;
	// Case table: levels, event pulse, expected error flags
	localparam logic [6:0] LV [8] = '{7'h20, 7'h10, 7'h08, 7'h00, 7'h02, 7'h0c, 7'h08, 7'h20};
	localparam logic [11:0] EV [8] = '{12'h200, 12'h100, 12'h010, 12'h010, 12'h008,
		12'h004, 12'h002, 12'h001};
	localparam logic [7:0] EXP [8] = '{8'h80, 8'h10, 8'h08, 8'h00, 8'h04, 8'h02, 8'h01, 8'h01};
	// Fan the vectors out to the named inputs
	assign {cmdStart, checksumAllProcessed, hostFifoWrite, engineFifoWrite, rfLastTxSent,
		rfLastRxDone, rxStartup, collisionSeen, checksumFail, parityFail, badStartOfFrame,
		authByteCountBad} = ev;
	assign {standalone_checksum_cmd, card_authenticate_cmd, fifoFull, rate106k, typeA,
		rx_checksum_check_enable, overheat} = lv;
	irq_and_error_status_regs DUT (.*);
	host_model HOST (.*);
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h got %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic [11:0] m);
		@(posedge clk) ev <= m;
		@(posedge clk) ev <= 12'h000;
		idle(1);
	endtask
	task automatic test_reset;
		HOST.rd(6'h05, rd);
		chk("misc low nibble", 8'h00, rd & 8'h0f);
		HOST.rd(6'h06, rd);
		chk("error reg", 8'h00, rd);
		HOST.rd(6'h3f, rd);
		chk("unmapped", 8'h00, rd);
		$display("test_reset done");
	endtask
	task automatic test_misc;
		@(posedge clk) card_side_serial_input <= 1'b1;
		idle(8);
		chk("rising edge", 8'h10, misc_irq_flags);
		HOST.wr(6'h05, 8'h10);
		idle(2);
		chk("clear bit 4", 8'h00, misc_irq_flags);
		@(posedge clk) card_side_serial_input <= 1'b0;
		@(posedge clk) lv <= 7'h40;
		pulse(12'h400);
		idle(10);
		chk("edge and checksum", 8'h14, misc_irq_flags);
		HOST.wr(6'h05, 8'hff);
		idle(2);
		chk("set all", 8'h14, misc_irq_flags);
		HOST.wr(6'h05, 8'h7f);
		HOST.rd(6'h05, rd);
		chk("clear all", 8'h00, rd);
		$display("test_misc done");
	endtask
	task automatic test_errors;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) lv <= LV[i];
			pulse(EV[i]);
			chk("event flag", EXP[i], command_error_flags);
			chk("error irq", {7'h00, EXP[i] != 8'h00}, {7'h00, any_error_irq});
			pulse(12'h800);
			chk("command clear", 8'h00, command_error_flags);
		end
		@(posedge clk) lv <= 7'h00;
		pulse(12'h080);
		pulse(12'h200);
		chk("rf window write", 8'h80, command_error_flags);
		pulse(12'h800);
		pulse(12'h040);
		pulse(12'h200);
		chk("after window", 8'h00, command_error_flags);
		@(posedge clk) lv <= 7'h1e;
		pulse(12'h11e);
		chk("all rx flags", 8'h1f, command_error_flags);
		pulse(12'h020);
		chk("rx startup", 8'h10, command_error_flags);
		HOST.wr(6'h06, 8'hff);
		HOST.rd(6'h06, rd);
		chk("read only", 8'h10, rd);
		@(posedge clk) lv <= 7'h01;
		idle(6);
		chk("overheat", 8'h50, command_error_flags);
		chk("antenna off", 8'h01, {7'h00, antennaOff});
		pulse(12'h800);
		chk("temp kept", 8'h40, command_error_flags);
		$display("test_errors done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard, well above the roughly 150 cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end
	// Reset for four cycles, then the scenarios
	initial begin
		nrst = 1'b0;
		ev = 12'h000;
		lv = 7'h00;
		card_side_serial_input = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		test_reset();
		test_misc();
		test_errors();
		print_verdict();
	end
endmodule
